// File: logic/hst_core.sv
// Top of the high-speed timer core: AXI4-Lite register slave, shared
// high-bits buffer, sync stages, prescaler and interrupt flags.
// Assumes the fast peripheral clock and fault arrive as raw pins.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module hst_core
  import hst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite write
  input wire logic [HST_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [HST_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic fast_peripheral_clock,
  input wire logic fault_in,
  output logic wave_out_a,
  output logic wave_out_a_inv,
  output logic wave_out_b,
  output logic wave_out_b_inv,
  output logic wave_out_d,
  output logic wave_out_d_inv,
  // Interrupt requests and service acknowledge
  output logic [4:0] irq_req,
  input wire logic [4:0] irq_ack
);

  typedef struct packed {
    logic aw_ok;
    logic [HST_AW-1:0] aw_addr;
    logic w_ok;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0][7:0] ctrl;
    logic [3:0][HST_CW-1:0] cmp;
    logic [1:0] hb;
    logic [1:0] hb_rd;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [1:0][2:0][7:0] ctrl_s;
    logic [1:0][3:0][HST_CW-1:0] cmp_s;
    logic [1:0] ld_s;
    logic [1:0][HST_CW-1:0] ldv_s;
    logic [1:0][HST_CW-1:0] cnt_s;
    logic [2:0] pck_s;
    logic pck_stable;
    logic half;
    logic [2:0] flt_s;
    logic flt_stable;
    logic [HST_PW-1:0] presc;
    logic tick;
    logic [4:0] irq;
  } hst_core_st_t;

  hst_core_st_t st_ff;
  hst_core_st_t nxt_st;

  hst_eng_if eng_if ();

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic hst_reg_t reg_sel(input logic [HST_AW-1:0] a);
    case (a)
      OFF_CTRL_A: reg_sel = RG_CTRL_A;
      OFF_CTRL_B: reg_sel = RG_CTRL_B;
      OFF_CTRL_C: reg_sel = RG_CTRL_C;
      OFF_CTRL_D: reg_sel = RG_CTRL_D;
      OFF_COUNT: reg_sel = RG_COUNT;
      OFF_HIGH: reg_sel = RG_HIGH;
      OFF_CMP_A: reg_sel = RG_CMP_A;
      OFF_CMP_B: reg_sel = RG_CMP_B;
      OFF_TOP: reg_sel = RG_TOP;
      OFF_CMP_D: reg_sel = RG_CMP_D;
      OFF_FLAGS: reg_sel = RG_FLAGS;
      OFF_MASK: reg_sel = RG_MASK;
      default: reg_sel = RG_NONE;
    endcase
  endfunction

  function automatic logic [1:0] cmp_idx(input hst_reg_t r);
    case (r)
      RG_CMP_A: cmp_idx = 2'(CI_A);
      RG_CMP_B: cmp_idx = 2'(CI_B);
      RG_TOP: cmp_idx = 2'(CI_TOP);
      default: cmp_idx = 2'(CI_D);
    endcase
  endfunction

  function automatic logic [HST_PW-1:0] presc_mask(input logic [CA_CS_W-1:0] cs);
    if (cs == CS_STOP) begin
      presc_mask = '0;
    end else begin
      presc_mask = (PRESC_ONE << (cs - CS_ONE)) - PRESC_ONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic pck_edge;
  logic flt_rise;
  logic src_tick;
  logic [CA_CS_W-1:0] cs;
  logic [HST_PW-1:0] pm;
  logic [3:0] fl_clr;
  logic ff_clr;
  hst_reg_t rsel;
  hst_reg_t wsel;

  always_comb begin
    nxt_st = st_ff;
    fl_clr = irq_ack[3:0];
    ff_clr = irq_ack[IRQ_FAULT];
    rsel = reg_sel(s_axi_araddr);
    wsel = reg_sel(st_ff.aw_addr);

    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_en = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Pin synchronisers; a change counts when stages two and three agree
    nxt_st.pck_s = {st_ff.pck_s[1:0], fast_peripheral_clock};
    nxt_st.flt_s = {st_ff.flt_s[1:0], fault_in};
    pck_edge = (st_ff.pck_s[1] == st_ff.pck_s[2]) && st_ff.pck_s[2] && !st_ff.pck_stable;
    flt_rise = (st_ff.flt_s[1] == st_ff.flt_s[2]) && st_ff.flt_s[2] && !st_ff.flt_stable;
    if (st_ff.pck_s[1] == st_ff.pck_s[2]) begin
      nxt_st.pck_stable = st_ff.pck_s[2];
    end
    if (st_ff.flt_s[1] == st_ff.flt_s[2]) begin
      nxt_st.flt_stable = st_ff.flt_s[2];
    end
    if (pck_edge) begin
      nxt_st.half = !st_ff.half;
    end

    // Prescaler on system clock or fast peripheral clock
    if (st_ff.ctrl_s[1][0][CA_ASYNC]) begin
      src_tick = pck_edge && (!st_ff.ctrl_s[1][0][CA_LSM] || st_ff.half);
    end else begin
      src_tick = 1'b1;
    end
    cs = st_ff.ctrl_s[1][0][CA_CS_LSB +: CA_CS_W];
    pm = presc_mask(cs);
    if (src_tick) begin
      nxt_st.presc = st_ff.presc + PRESC_ONE;
    end
    nxt_st.tick = src_tick && (cs != CS_STOP) && ((st_ff.presc & pm) == pm);

    // Input sync stages toward the counter, output stages back
    nxt_st.ctrl_s[0] = st_ff.ctrl[2:0];
    nxt_st.ctrl_s[1] = st_ff.ctrl_s[0];
    nxt_st.cmp_s[0] = st_ff.cmp;
    nxt_st.cmp_s[1] = st_ff.cmp_s[0];
    nxt_st.ld_s = {st_ff.ld_s[0], 1'b0};
    nxt_st.ldv_s[1] = st_ff.ldv_s[0];
    nxt_st.cnt_s = {st_ff.cnt_s[0], eng_if.cnt};
    nxt_st.hb_rd = st_ff.hb;

    // Register read
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      case (rsel)
        RG_CTRL_A, RG_CTRL_B, RG_CTRL_C: begin
          nxt_st.rdata[7:0] = st_ff.ctrl[rsel[1:0]];
        end
        RG_CTRL_D: begin
          nxt_st.rdata[7:0] = st_ff.ctrl[3];
        end
        RG_COUNT: begin
          nxt_st.rdata[7:0] = st_ff.cnt_s[1][7:0];
          nxt_st.hb = st_ff.cnt_s[1][9:8];
        end
        RG_HIGH: begin
          nxt_st.rdata[1:0] = st_ff.hb_rd;
        end
        RG_CMP_A, RG_CMP_B, RG_TOP, RG_CMP_D: begin
          nxt_st.rdata[7:0] = st_ff.cmp[cmp_idx(rsel)][7:0];
          nxt_st.hb = st_ff.cmp[cmp_idx(rsel)][9:8];
        end
        RG_FLAGS: begin
          nxt_st.rdata[3:0] = st_ff.flags;
        end
        RG_MASK: begin
          nxt_st.rdata[3:0] = st_ff.mask;
        end
        default: begin
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Register write once both halves are held
    if (st_ff.aw_ok && st_ff.w_ok) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wsel == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (st_ff.w_en) begin
        case (wsel)
          RG_CTRL_A, RG_CTRL_B, RG_CTRL_C: begin
            nxt_st.ctrl[wsel[1:0]] = st_ff.w_data;
          end
          RG_CTRL_D: begin
            nxt_st.ctrl[3][7:1] = st_ff.w_data[7:1];
            ff_clr = ff_clr || st_ff.w_data[CD_FF];
          end
          RG_COUNT: begin
            nxt_st.ld_s[0] = 1'b1;
            nxt_st.ldv_s[0] = {st_ff.hb, st_ff.w_data};
          end
          RG_HIGH: begin
            nxt_st.hb = st_ff.w_data[1:0];
          end
          RG_CMP_A, RG_CMP_B, RG_TOP, RG_CMP_D: begin
            nxt_st.cmp[cmp_idx(wsel)] = {st_ff.hb, st_ff.w_data};
          end
          RG_FLAGS: begin
            fl_clr = fl_clr | st_ff.w_data[3:0];
          end
          RG_MASK: begin
            nxt_st.mask = st_ff.w_data[3:0];
          end
          default: begin
            nxt_st.mask = st_ff.mask;
          end
        endcase
      end
    end

    // Flags: a new event beats a clear in the same cycle
    nxt_st.flags = (st_ff.flags & ~fl_clr) |
                   {eng_if.match[2], eng_if.match[1], eng_if.match[0], eng_if.ovf};
    nxt_st.ctrl[3][CD_FF] = (st_ff.ctrl[3][CD_FF] && !ff_clr) ||
                            (flt_rise && st_ff.ctrl_s[1][2][CC_FAULT_EN]);
    nxt_st.irq = {st_ff.ctrl[3][CD_FF] && st_ff.ctrl[3][CD_FIE],
                  st_ff.flags & st_ff.mask};

    if (srst) begin
      nxt_st = '0;
      nxt_st.cmp[CI_TOP] = CNT_MAX;
      nxt_st.cmp_s[0][CI_TOP] = CNT_MAX;
      nxt_st.cmp_s[1][CI_TOP] = CNT_MAX;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  assign eng_if.tick = st_ff.tick;
  assign eng_if.load = st_ff.ld_s[1];
  assign eng_if.load_val = st_ff.ldv_s[1];
  assign eng_if.cmp = {st_ff.cmp_s[1][CI_D],
                       st_ff.cmp_s[1][CI_B],
                       st_ff.cmp_s[1][CI_A]};
  assign eng_if.top = st_ff.cmp_s[1][CI_TOP];
  assign eng_if.pwm_en = st_ff.ctrl_s[1][0][CA_PWM];
  assign eng_if.act = st_ff.ctrl_s[1][1][2*HST_NCH-1:0];
  assign eng_if.eight_bit = (st_ff.cmp_s[1][CI_A][9:8] == 2'h0) &&
                            (st_ff.cmp_s[1][CI_B][9:8] == 2'h0) &&
                            (st_ff.cmp_s[1][CI_TOP][9:8] == 2'h0) &&
                            (st_ff.cmp_s[1][CI_D][9:8] == 2'h0);
  assign eng_if.kill = st_ff.flt_stable && st_ff.ctrl_s[1][2][CC_FAULT_EN];

  hst_engine u_engine (
    .clk (clk),
    .srst (srst),
    .eng (eng_if.eng)
  );

  assign wave_out_a = eng_if.wave_p[0];
  assign wave_out_a_inv = eng_if.wave_n[0];
  assign wave_out_b = eng_if.wave_p[1];
  assign wave_out_b_inv = eng_if.wave_n[1];
  assign wave_out_d = eng_if.wave_p[2];
  assign wave_out_d_inv = eng_if.wave_n[2];
  assign irq_req = st_ff.irq;

endmodule

// File: logic/hst_pkg.sv
// Package for the high-speed timer core: register map, field layout,
// reset values and waveform action codes.
// Assumes an 8-bit byte-addressed window on a 32-bit AXI4-Lite slave.
package hst_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HST_CW = 10;
  localparam int HST_AW = 8;
  localparam int HST_PW = 14;
  localparam int HST_NCH = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CTRL_C = 8'h08;
  localparam logic [7:0] OFF_CTRL_D = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_HIGH = 8'h14;
  localparam logic [7:0] OFF_CMP_A = 8'h18;
  localparam logic [7:0] OFF_CMP_B = 8'h1c;
  localparam logic [7:0] OFF_TOP = 8'h20;
  localparam logic [7:0] OFF_CMP_D = 8'h24;
  localparam logic [7:0] OFF_FLAGS = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2c;

  typedef enum logic [3:0] {
    RG_CTRL_A, RG_CTRL_B, RG_CTRL_C, RG_CTRL_D, RG_COUNT, RG_HIGH,
    RG_CMP_A, RG_CMP_B, RG_TOP, RG_CMP_D, RG_FLAGS, RG_MASK, RG_NONE
  } hst_reg_t;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CA_CS_LSB = 0;
  localparam int CA_CS_W = 4;
  localparam int CA_ASYNC = 4;
  localparam int CA_LSM = 5;
  localparam int CA_PWM = 6;
  localparam int CB_ACT_W = 2;
  localparam int CC_FAULT_EN = 0;
  localparam int CD_FIE = 1;
  localparam int CD_FF = 0;
  localparam int FL_OVF = 0;
  localparam int FL_A = 1;
  localparam int FL_B = 2;
  localparam int FL_D = 3;
  localparam int IRQ_FAULT = 4;
  localparam int CI_A = 0;
  localparam int CI_B = 1;
  localparam int CI_TOP = 2;
  localparam int CI_D = 3;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam logic [9:0] CNT_BOTTOM = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h0ff;
  localparam logic [3:0] CS_STOP = 4'h0;
  localparam logic [3:0] CS_ONE = 4'h1;
  localparam logic [13:0] PRESC_ONE = 14'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: logic/hst_eng_if.sv
// Carrier between the register side of the timer core and its counter engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface hst_eng_if;
  import hst_pkg::*;
  logic tick;
  logic load;
  logic [HST_CW-1:0] load_val;
  logic [HST_NCH-1:0][HST_CW-1:0] cmp;
  logic [HST_CW-1:0] top;
  logic pwm_en;
  logic [HST_NCH-1:0][CB_ACT_W-1:0] act;
  logic eight_bit;
  logic kill;
  logic [HST_CW-1:0] cnt;
  logic ovf;
  logic [HST_NCH-1:0] match;
  logic [HST_NCH-1:0] wave_p;
  logic [HST_NCH-1:0] wave_n;

  modport core (
    output tick, load, load_val, cmp, top, pwm_en, act, eight_bit, kill,
    input cnt, ovf, match, wave_p, wave_n
  );
  modport eng (
    input tick, load, load_val, cmp, top, pwm_en, act, eight_bit, kill,
    output cnt, ovf, match, wave_p, wave_n
  );
endinterface

// File: logic/hst_engine.sv
// Counter engine of the high-speed timer: 10-bit counter, compare
// channels A, B, D and complementary wave outputs.
// Assumes tick, load and settings already crossed the sync stages.
`timescale 1ns/100ps
module hst_engine
  import hst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core side
  hst_eng_if.eng eng
);

  typedef struct packed {
    logic [HST_CW-1:0] cnt;
    logic block;
    logic [HST_NCH-1:0] wave;
    logic [HST_NCH-1:0] wave_d;
    logic [HST_NCH-1:0] out_p;
    logic [HST_NCH-1:0] out_n;
    logic ovf;
    logic [HST_NCH-1:0] match;
  } hst_eng_st_t;

  hst_eng_st_t st_ff;
  hst_eng_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ovf = 1'b0;
    nxt_st.match = '0;
    if (eng.tick) begin
      nxt_st.block = 1'b0;
      for (int i = 0; i < HST_NCH; i++) begin
        if ((st_ff.cnt == eng.cmp[i]) && !st_ff.block) begin
          nxt_st.match[i] = 1'b1;
        end
      end
      if (st_ff.cnt == eng.top) begin
        nxt_st.cnt = CNT_BOTTOM;
        nxt_st.ovf = 1'b1;
      end else if (eng.eight_bit) begin
        nxt_st.cnt = {2'h0, st_ff.cnt[7:0] + 8'h01};
      end else begin
        nxt_st.cnt = st_ff.cnt + 10'h001;
      end
    end
    // Write wins over count and clear
    if (eng.load) begin
      nxt_st.cnt = eng.load_val;
      nxt_st.block = 1'b1;
    end
    for (int i = 0; i < HST_NCH; i++) begin
      if (eng.pwm_en) begin
        nxt_st.wave[i] = (st_ff.cnt < eng.cmp[i]);
      end else if (nxt_st.match[i]) begin
        case (eng.act[i])
          ACT_TOGGLE: nxt_st.wave[i] = !st_ff.wave[i];
          ACT_CLEAR: nxt_st.wave[i] = 1'b0;
          ACT_SET: nxt_st.wave[i] = 1'b1;
          default: nxt_st.wave[i] = st_ff.wave[i];
        endcase
      end
      // One clock of dead time on every edge
      nxt_st.out_p[i] = !eng.kill && st_ff.wave[i] && st_ff.wave_d[i];
      nxt_st.out_n[i] = !eng.kill && !st_ff.wave[i] && !st_ff.wave_d[i];
    end
    nxt_st.wave_d = st_ff.wave;
    if (srst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign eng.cnt = st_ff.cnt;
  assign eng.ovf = st_ff.ovf;
  assign eng.match = st_ff.match;
  assign eng.wave_p = st_ff.out_p;
  assign eng.wave_n = st_ff.out_n;

endmodule

// File: testbench/hst_core_chk.sv
// Port checker for the high-speed timer core.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/100ps
module hst_core_chk
  import hst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [HST_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic wave_out_a,
  input wire logic wave_out_a_inv,
  input wire logic wave_out_b,
  input wire logic wave_out_b_inv,
  input wire logic wave_out_d,
  input wire logic wave_out_d_inv,
  input wire logic [4:0] irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_pair_apart: assert property (
    !(wave_out_a && wave_out_a_inv) && !(wave_out_b && wave_out_b_inv)
    && !(wave_out_d && wave_out_d_inv)) else $error("wave pair overlaps");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > OFF_MASK)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_fault_irq: cover property (irq_req[IRQ_FAULT]);
  c_wave: cover property ($rose(wave_out_a));
endmodule

bind hst_core hst_core_chk i_chk (
  .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_out_a, .wave_out_a_inv, .wave_out_b,
  .wave_out_b_inv, .wave_out_d, .wave_out_d_inv, .irq_req
);

// File: testbench/hst_cpu_model.sv
// Bus master standing in for the processor on the register bus.
// Assumes the caller enters a task only after the previous one returned.
`timescale 1ns/100ps
module hst_cpu_model
  import hst_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write channels
  output logic [HST_AW-1:0] s_axi_awaddr = 8'h00,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'h0,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  // Read channels
  output logic [HST_AW-1:0] s_axi_araddr = 8'h00,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// File: testbench/test_high_speed_timer_core.sv
// Self-checking bench of the high-speed timer core.
// Assumes the package, design, checker and bus model are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (a), (e)); end end
module test_high_speed_timer_core
  import hst_pkg::*;
;
  localparam logic [7:0] OFFS [12] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_CTRL_C, OFF_CTRL_D,
    OFF_COUNT, OFF_HIGH, OFF_CMP_A, OFF_CMP_B, OFF_TOP, OFF_CMP_D, OFF_FLAGS, OFF_MASK};
  localparam logic [7:0] RB_OFF [6] = '{OFF_CTRL_B, OFF_CTRL_C, OFF_CMP_A, OFF_CMP_B,
    OFF_CMP_D, OFF_TOP};
  localparam logic [7:0] RB_VAL [6] = '{8'h2d, 8'h01, 8'h5a, 8'h3c, 8'h77, 8'hc3};
  localparam logic [7:0] AS_CTL [3] = '{8'h11, 8'h31, 8'h11};
  localparam logic AS_RUN [3] = '{1'b1, 1'b1, 1'b0};
  localparam logic [7:0] AS_EXP [3] = '{8'h03, 8'h02, 8'h00};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fast_peripheral_clock = 1'b0;
  logic fclk_run = 1'b0;
  logic fault_in = 1'b0;
  logic [4:0] irq_ack = 5'h00;
  logic [4:0] irq_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, cnt0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic wave_out_a, wave_out_a_inv, wave_out_b, wave_out_b_inv, wave_out_d, wave_out_d_inv;
  int num_errors = 0;
  int comparisons = 0;
  int hi;
  int lo;

  hst_core i_dut (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fast_peripheral_clock, .fault_in, .wave_out_a, .wave_out_a_inv, .wave_out_b,
    .wave_out_b_inv, .wave_out_d, .wave_out_d_inv, .irq_req, .irq_ack
  );
  hst_cpu_model i_cpu (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial begin
    forever #2 clk = ~clk;
  end
  // Fast clock parks low while gated off; offset keeps it off the system clock edges
  initial begin
    #1;
    forever #10 fast_peripheral_clock = fclk_run && !fast_peripheral_clock;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_cpu.wr(a, d, rs);
    `CHK(rs, RESP_OKAY)
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    i_cpu.rd(a, rd, rs);
    `CHK({rs, rd}, {RESP_OKAY, 24'h0, e})
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (OFFS[i]) r(OFFS[i], (OFFS[i] == OFF_TOP) ? CNT_MAX[7:0] : 8'h00);
    $display("done: reset values");
    foreach (RB_OFF[i]) begin
      w(RB_OFF[i], RB_VAL[i]);
      r(RB_OFF[i], RB_VAL[i]);
    end
    w(OFF_CTRL_B, 8'h00);
    w(OFF_CTRL_C, 8'h00);
    w(OFF_HIGH, 8'h03);
    w(OFF_CMP_A, 8'h5a);
    w(OFF_HIGH, 8'h00);
    r(OFF_CMP_A, 8'h5a);
    r(OFF_HIGH, 8'h03);
    $display("done: read back and upper bits");
    w(OFF_HIGH, 8'h00);
    w(OFF_TOP, 8'h0f);
    w(OFF_CMP_A, 8'h05);
    w(OFF_CMP_B, 8'h20);
    w(OFF_CMP_D, 8'h20);
    w(OFF_MASK, 8'h0f);
    w(OFF_CTRL_A, {4'h0, CS_ONE});
    repeat (40) @(posedge clk);
    w(OFF_CTRL_A, 8'h00);
    repeat (8) @(posedge clk);
    r(OFF_FLAGS, 8'h03);
    `CHK(irq_req, 5'h03)
    i_cpu.rd(OFF_COUNT, cnt0, rs);
    `CHK(cnt0 < 32'h10, 1'b1)
    repeat (20) @(posedge clk);
    r(OFF_COUNT, cnt0[7:0]);
    w(OFF_FLAGS, 8'h01);
    repeat (4) @(posedge clk);
    r(OFF_FLAGS, 8'h02);
    irq_ack <= 5'h02;
    @(posedge clk);
    irq_ack <= 5'h00;
    repeat (4) @(posedge clk);
    r(OFF_FLAGS, 8'h00);
    `CHK(irq_req, 5'h00)
    $display("done: counting and flags");
    w(OFF_COUNT, 8'h05);
    repeat (6) @(posedge clk);
    r(OFF_COUNT, 8'h05);
    w(OFF_CTRL_A, {4'h0, CS_ONE});
    w(OFF_CTRL_A, 8'h00);
    repeat (8) @(posedge clk);
    r(OFF_FLAGS, 8'h00);
    i_cpu.rd(OFF_COUNT, rd, rs);
    `CHK(rd > 32'h5, 1'b1)
    i_cpu.wr(8'h30, 8'h55, rs);
    `CHK(rs, RESP_SLVERR)
    i_cpu.rd(8'h30, rd, rs);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
    $display("done: counter write and unmapped");
    w(OFF_CMP_A, 8'h08);
    w(OFF_CTRL_A, 8'h41);
    hi = 0;
    lo = 0;
    repeat (64) begin
      @(posedge clk);
      hi += int'(wave_out_a);
      lo += int'(wave_out_a_inv);
    end
    `CHK(hi >= 24 && hi <= 32, 1'b1)
    `CHK(hi + lo > 48 && hi + lo < 64, 1'b1)
    `CHK({wave_out_b, wave_out_b_inv, wave_out_d, wave_out_d_inv}, 4'ha)
    w(OFF_CTRL_C, 8'h01);
    w(OFF_CTRL_D, 8'h02);
    fault_in <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({wave_out_a, wave_out_a_inv, wave_out_b, wave_out_b_inv}, 4'h0)
    `CHK({wave_out_d, wave_out_d_inv}, 2'h0)
    `CHK(irq_req[IRQ_FAULT], 1'b1)
    r(OFF_CTRL_D, 8'h03);
    fault_in <= 1'b0;
    w(OFF_CTRL_D, 8'h03);
    repeat (4) @(posedge clk);
    r(OFF_CTRL_D, 8'h02);
    w(OFF_CTRL_A, 8'h00);
    w(OFF_CTRL_C, 8'h00);
    $display("done: pwm and fault");
    foreach (AS_CTL[i]) begin
      fclk_run <= AS_RUN[i];
      w(OFF_FLAGS, 8'h0f);
      w(OFF_COUNT, 8'h00);
      w(OFF_CTRL_A, AS_CTL[i]);
      repeat (120) @(posedge clk);
      w(OFF_CTRL_A, 8'h00);
      repeat (8) @(posedge clk);
      r(OFF_FLAGS, AS_EXP[i]);
    end
    $display("done: async clock");
    end_of_test();
  end
endmodule
